// file: hw/adcsr_regs.sv
// Status word, correction registers and parallel-bus access of the ADC back end.
`timescale 1ns/100ps
`include "adcsr_params.svh"
// ==========================================================================
// Notes on behaviour
// - Status bits 15:14 hold fixed part code.
// - Status bits 13:11 show the die index.
// - Status bit 10 mirrors result valid flag.
// - Status bit 9 shows low power mode.
// - Bit 8 set when input exceeds threshold.
// - Bit 7 set when download checksum matches.
// - Bit 6 set when filter pass checksum matches.
// - Bit 5 set while custom filter used.
// - Bit 4 echoes third stage bypass control.
// - Bit 3 echoes first stage bypass control.
// - Bits 2:0 echo decimation select.
// - Offset is two's complement, resets zero.
// - Offset applied after gain correction.
// - Gain 0x8000 is unity, resets 0xa000.
// - Threshold compared on first stage output.
// - Threshold resets to 0xcccc.
// - Over four full-scale modulator samples flags overrange.
// - Read-select status returns status on next read.
module adcsr_regs #(
   parameter int COEF_DEPTH = 128, // Coefficient store depth.
   parameter int COEF_PER_FLEN = 8 // Coefficients per filter length step.
) (
   input wire logic core_clk, // System clock, 100 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic bus_cs_n, // Chip select pin.
   input wire logic bus_wr_n, // Write strobe pin.
   input wire logic bus_rd_n, // Read strobe pin.
   input wire logic [15:0] bus_data_in, // Data bus input side.
   output logic [15:0] bus_data_out, // Data bus output side.
   output logic bus_data_oe, // Data bus output enable.
   input wire logic [2:0] die_strap, // Die index strap pins.
   input wire logic signed [15:0] stage1_data, // First decimation stage output.
   input wire logic stage1_valid, // New first stage sample.
   input wire logic mod_over_fs, // Modulator sample beyond full scale.
   input wire logic mod_valid, // New modulator sample.
   input wire logic signed [23:0] raw_result, // Uncorrected filter result.
   input wire logic raw_valid, // New uncorrected result.
   input wire logic filt_coef_pass, // Coefficients are passing through the filter.
   output logic signed [23:0] result_out, // Corrected result.
   output logic result_valid_out, // Pulse with each corrected result.
   output logic [15:0] device_status_word, // Live status word.
   output logic low_power_flag, // Low power mode request.
   output logic third_stage_pass_flag, // Third stage bypass control.
   output logic first_stage_pass_flag, // First stage bypass control.
   output logic [2:0] decimation_select, // Decimation select.
   output logic [3:0] filt_len, // Filter length setting.
   output logic sync_pulse, // One-cycle synchronisation request.
   output logic power_down, // Power down request.
   output logic amp_power_down, // Amplifier power down request.
   output logic clk_div_bypass // Clock divider setting.
);
   // ========================================================================
   // Pin synchronisers.
   logic [2:0] strb_s1_r; // First stage, read only by the second.
   logic [2:0] strb_s2_r; // Second stage: cs_n, wr_n, rd_n.
   logic [15:0] din_s1_r; // Data first stage.
   logic [15:0] din_s2_r; // Data second stage.
   logic [2:0] die_s1_r; // Strap first stage.
   logic [2:0] die_s2_r; // Strap second stage.
   logic [2:0] strb_d_r; // Delayed copy for edge detection.

   // Every pin passes two flops before any logic looks at it.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strb_s1_r <= 3'h7;
         strb_s2_r <= 3'h7;
         strb_d_r <= 3'h7;
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
         die_s1_r <= 3'h0;
         die_s2_r <= 3'h0;
      end else begin
         strb_s1_r <= {bus_cs_n, bus_wr_n, bus_rd_n};
         strb_s2_r <= strb_s1_r;
         strb_d_r <= strb_s2_r;
         din_s1_r <= bus_data_in;
         din_s2_r <= din_s1_r;
         die_s1_r <= die_strap;
         die_s2_r <= die_s1_r;
      end
   end

   // Write is taken on the rising edge of the write strobe under select, so
   // the data has had the whole low phase to settle through the synchroniser.
   logic wr_take;
   logic rd_start;
   logic rd_end;
   assign wr_take = !strb_s2_r[2] && strb_s2_r[1] && !strb_d_r[1];
   assign rd_start = !strb_s2_r[2] && !strb_s2_r[0] && strb_d_r[0];
   assign rd_end = !strb_s2_r[0] ? 1'b0 : !strb_d_r[0];

   // ========================================================================
   // Register state.
   logic [15:0] ctrl1_r; // Persistent part of control register 1.
   logic [15:0] ctrl2_r; // Control register 2.
   logic [15:0] offset_correction_r; // Signed offset.
   logic [15:0] gain_correction_r; // Gain, 0x8000 is unity.
   logic [15:0] overrange_threshold_r; // Overrange threshold.
   logic [2:0] die_r; // Die index, resampled every clock.
   logic [15:0] addr_r; // Address from the address phase.
   adcsr_pkg::adcsr_wphase_t wphase_r; // Write protocol phase.
   adcsr_pkg::adcsr_rdsel_t rdsel_r; // Source of the next read.
   logic sync_r; // Synchronisation pulse.

   // Die index is a strap: resampled on every clock, never loaded by reset.
   always_ff @(posedge core_clk) begin
      die_r <= die_s2_r;
   end

   // Coefficient download bookkeeping.
   logic [15:0] coef_mem [COEF_DEPTH]; // Downloaded coefficients.
   logic [$clog2(COEF_DEPTH)-1:0] coef_idx_r; // Write index.
   logic [$clog2(COEF_DEPTH):0] coef_cnt_r; // Coefficients still expected.
   logic [15:0] dl_sum_r; // Checksum accumulated during download.
   logic [15:0] dl_ref_r; // Checksum word sent by the host.
   logic download_checksum_match_r; // Download checksum matched.
   logic custom_r; // Custom filter in use.

   // Address/data sequencing and register writes.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wphase_r <= adcsr_pkg::ADCSR_WR_ADDR;
         addr_r <= 16'h0000;
         ctrl1_r <= `ADCSR_RST_CTRL1;
         ctrl2_r <= `ADCSR_RST_CTRL2;
         offset_correction_r <= `ADCSR_RST_OFFSET;
         gain_correction_r <= `ADCSR_RST_GAIN;
         overrange_threshold_r <= `ADCSR_RST_OVR_THR;
         sync_r <= 1'b0;
      end else begin
         sync_r <= 1'b0;
         if (wr_take) begin
            unique case (wphase_r)
               adcsr_pkg::ADCSR_WR_ADDR: begin
                  addr_r <= din_s2_r;
                  wphase_r <= adcsr_pkg::ADCSR_WR_DATA;
               end
               adcsr_pkg::ADCSR_WR_DATA: begin
                  wphase_r <= adcsr_pkg::ADCSR_WR_ADDR;
                  // Unknown addresses are dropped silently.
                  if (addr_r == `ADCSR_ADDR_CTRL1) begin
                     // Bits 15..9 are self-clearing, so only 8..0 persist.
                     ctrl1_r <= {7'h00, din_s2_r[8:0]};
                     sync_r <= din_s2_r[`ADCSR_C1_SYNC];
                     if (din_s2_r[`ADCSR_C1_DL_FILT]) begin
                        wphase_r <= adcsr_pkg::ADCSR_WR_COEF;
                     end
                  end else if (addr_r == `ADCSR_ADDR_CTRL2) begin
                     ctrl2_r <= din_s2_r;
                  end else if (addr_r == `ADCSR_ADDR_OFFSET) begin
                     offset_correction_r <= din_s2_r;
                  end else if (addr_r == `ADCSR_ADDR_GAIN) begin
                     gain_correction_r <= din_s2_r;
                  end else if (addr_r == `ADCSR_ADDR_OVR_THR) begin
                     overrange_threshold_r <= din_s2_r;
                  end
               end
               // Coefficient words carry no address; the last is the checksum.
               adcsr_pkg::ADCSR_WR_COEF: begin
                  if (coef_cnt_r == '0) begin
                     wphase_r <= adcsr_pkg::ADCSR_WR_ADDR;
                  end
               end
            endcase
         end
      end
   end

   // Download: count coefficients, sum them, then compare with the checksum.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         coef_idx_r <= '0;
         coef_cnt_r <= '0;
         dl_sum_r <= 16'h0000;
         dl_ref_r <= 16'h0000;
         download_checksum_match_r <= 1'b0;
         custom_r <= 1'b0;
      end else if (wr_take && wphase_r == adcsr_pkg::ADCSR_WR_DATA &&
                   addr_r == `ADCSR_ADDR_CTRL1 && din_s2_r[`ADCSR_C1_DL_FILT]) begin
         // Count is (length + 1) steps; a long filter is clipped to the store.
         coef_cnt_r <= ($clog2(COEF_DEPTH)+1)'(
            (int'(din_s2_r[8:5]) + 1) * COEF_PER_FLEN > COEF_DEPTH ? COEF_DEPTH :
            (int'(din_s2_r[8:5]) + 1) * COEF_PER_FLEN);
         coef_idx_r <= '0;
         dl_sum_r <= 16'h0000;
         download_checksum_match_r <= 1'b0;
         custom_r <= 1'b0;
      end else if (wr_take && wphase_r == adcsr_pkg::ADCSR_WR_COEF) begin
         if (coef_cnt_r != '0) begin
            coef_cnt_r <= coef_cnt_r - 1'b1;
            coef_idx_r <= coef_idx_r + 1'b1;
            dl_sum_r <= dl_sum_r + din_s2_r;
         end else begin
            dl_ref_r <= din_s2_r;
            download_checksum_match_r <= (din_s2_r == dl_sum_r);
            custom_r <= 1'b1;
         end
      end
   end

   // Coefficient store; unused entries keep stale data but are never summed.
   always_ff @(posedge core_clk) begin
      if (wr_take && wphase_r == adcsr_pkg::ADCSR_WR_COEF && coef_cnt_r != '0) begin
         coef_mem[coef_idx_r] <= din_s2_r;
      end
   end

   // ========================================================================
   // Filter pass checksum: while the filter signals a coefficient pass, the
   // stored words are read back one per cycle and summed afresh.
   logic [$clog2(COEF_DEPTH)-1:0] scan_idx_r; // Read index of the pass.
   logic [15:0] scan_sum_r; // Running sum of the pass.
   logic scan_busy_r; // A pass is in progress.
   logic filt_ok_r; // Pass checksum matched.

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         scan_idx_r <= '0;
         scan_sum_r <= 16'h0000;
         scan_busy_r <= 1'b0;
         filt_ok_r <= 1'b0;
      end else if (!custom_r) begin
         scan_busy_r <= 1'b0;
         filt_ok_r <= 1'b0;
      end else if (!scan_busy_r) begin
         scan_idx_r <= '0;
         scan_sum_r <= 16'h0000;
         scan_busy_r <= filt_coef_pass;
      end else if (scan_idx_r == coef_idx_r) begin
         filt_ok_r <= (scan_sum_r == dl_ref_r);
         scan_busy_r <= 1'b0;
      end else begin
         scan_sum_r <= scan_sum_r + coef_mem[scan_idx_r];
         scan_idx_r <= scan_idx_r + 1'b1;
      end
   end

   // ========================================================================
   // Overrange detection on the uncorrected first stage output and on runs of full-scale modulator samples.
   logic ovr_r; // Overrange flag.
   logic [2:0] mod_run_r; // Consecutive full-scale modulator samples.
   logic [16:0] mag; // Magnitude of the first stage sample, scaled to 16 bits.
   assign mag = stage1_data[15] ? 17'(-{stage1_data[15], stage1_data}) << 1 :
                17'({1'b0, stage1_data}) << 1;

   // The saturating run count avoids wrap back below the limit.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mod_run_r <= 3'h0;
      end else if (mod_valid) begin
         if (!mod_over_fs) begin
            mod_run_r <= 3'h0;
         end else if (mod_run_r <= `ADCSR_MOD_OVER_LIMIT) begin
            mod_run_r <= mod_run_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovr_r <= 1'b0;
      end else if (mod_valid && mod_over_fs && mod_run_r >= `ADCSR_MOD_OVER_LIMIT) begin
         ovr_r <= 1'b1;
      end else if (stage1_valid) begin
         ovr_r <= (mag > {1'b0, overrange_threshold_r}) || (mod_run_r > `ADCSR_MOD_OVER_LIMIT);
      end
   end

   // ========================================================================
   // Gain then offset correction, two pipeline stages.
   logic signed [40:0] prod; // Raw result times unsigned gain.
   logic signed [25:0] gained_r; // Result after gain, scaled back.
   logic gained_v_r; // Gain stage holds a new result.
   logic signed [26:0] sum; // Gained result plus scaled offset.
   assign prod = raw_result * $signed({1'b0, gain_correction_r});
   // Full-scale offset 0x7fff maps to 1/128 of the 24-bit range, i.e. x2 LSB.
   assign sum = 27'(gained_r) + 27'($signed({offset_correction_r, 1'b0}));

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gained_r <= '0;
         gained_v_r <= 1'b0;
      end else begin
         gained_r <= 26'(prod >>> 15);
         gained_v_r <= raw_valid;
      end
   end

   logic result_valid_flag; // Unread corrected result present.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         result_out <= 24'h000000;
         result_valid_out <= 1'b0;
      end else begin
         result_valid_out <= gained_v_r;
         if (gained_v_r) begin
            if (sum > 27'sh07fffff) begin
               result_out <= 24'h7fffff;
            end else if (sum < -27'sh0800000) begin
               result_out <= 24'h800000;
            end else begin
               result_out <= sum[23:0];
            end
         end
      end
   end

   // ========================================================================
   // Readback: a new result sets the valid flag, reading its first word
   // clears it; a new result in the same cycle wins.
   logic rd_second_r; // Next result read is the second word.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         result_valid_flag <= 1'b0;
         rd_second_r <= 1'b0;
         rdsel_r <= adcsr_pkg::ADCSR_RD_RESULT;
      end else begin
         if (result_valid_out) begin
            result_valid_flag <= 1'b1;
         end else if (rd_start && rdsel_r == adcsr_pkg::ADCSR_RD_RESULT && !rd_second_r) begin
            result_valid_flag <= 1'b0;
         end
         if (wr_take && wphase_r == adcsr_pkg::ADCSR_WR_DATA && addr_r == `ADCSR_ADDR_CTRL1) begin
            if (din_s2_r[`ADCSR_C1_RD_OVR]) rdsel_r <= adcsr_pkg::ADCSR_RD_OVR;
            else if (din_s2_r[`ADCSR_C1_RD_GAIN]) rdsel_r <= adcsr_pkg::ADCSR_RD_GAIN;
            else if (din_s2_r[`ADCSR_C1_RD_OFF]) rdsel_r <= adcsr_pkg::ADCSR_RD_OFF;
            else if (din_s2_r[`ADCSR_C1_RD_STAT]) rdsel_r <= adcsr_pkg::ADCSR_RD_STAT;
         end else if (rd_start) begin
            if (rdsel_r != adcsr_pkg::ADCSR_RD_RESULT) begin
               rdsel_r <= adcsr_pkg::ADCSR_RD_RESULT;
            end else begin
               rd_second_r <= !rd_second_r;
            end
         end
      end
   end

   // Status word assembly.
   logic [15:0] status;
   assign status = {`ADCSR_PART_CODE, die_r, result_valid_flag, ctrl2_r[`ADCSR_C2_LOW_POWER_FLAG],
                    ovr_r, download_checksum_match_r, filt_ok_r, custom_r, ctrl1_r[4:0]};

   // Bus drive: data is latched at the read edge and held while it is low.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_data_out <= 16'h0000;
         bus_data_oe <= 1'b0;
      end else begin
         if (rd_start) begin
            bus_data_oe <= 1'b1;
            unique case (rdsel_r)
               adcsr_pkg::ADCSR_RD_OVR: bus_data_out <= overrange_threshold_r;
               adcsr_pkg::ADCSR_RD_GAIN: bus_data_out <= gain_correction_r;
               adcsr_pkg::ADCSR_RD_OFF: bus_data_out <= offset_correction_r;
               adcsr_pkg::ADCSR_RD_STAT: bus_data_out <= status;
               adcsr_pkg::ADCSR_RD_RESULT: bus_data_out <= rd_second_r ?
                  {result_out[7:0], 2'b00, result_valid_flag, ovr_r, 4'h0} :
                  result_out[23:8];
            endcase
         end else if (rd_end || strb_s2_r[2]) begin
            bus_data_oe <= 1'b0;
         end
      end
   end

   // Control outputs, all from flops.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         device_status_word <= 16'h0000;
         low_power_flag <= 1'b0;
         third_stage_pass_flag <= 1'b0;
         first_stage_pass_flag <= 1'b0;
         decimation_select <= 3'h0;
         filt_len <= 4'h0;
         sync_pulse <= 1'b0;
         power_down <= 1'b0;
         amp_power_down <= 1'b0;
         clk_div_bypass <= 1'b0;
      end else begin
         device_status_word <= status;
         low_power_flag <= ctrl2_r[`ADCSR_C2_LOW_POWER_FLAG];
         third_stage_pass_flag <= ctrl1_r[`ADCSR_C1_BYP3];
         first_stage_pass_flag <= ctrl1_r[`ADCSR_C1_BYP1];
         decimation_select <= ctrl1_r[2:0];
         filt_len <= ctrl1_r[8:5];
         sync_pulse <= sync_r;
         power_down <= ctrl2_r[`ADCSR_C2_PD];
         amp_power_down <= ctrl2_r[`ADCSR_C2_AMP_PD];
         clk_div_bypass <= ctrl2_r[`ADCSR_C2_CDIV];
      end
   end
endmodule : adcsr_regs

// file: pkg/adcsr_params.svh
// Offsets, field positions, reset values and fixed codes of the ADC status and correction bank.
`ifndef ADCSR_PARAMS_SVH
`define ADCSR_PARAMS_SVH
// ==========================================================================
// Register addresses, as written in the address phase of the parallel bus.
`define ADCSR_ADDR_CTRL1 16'h0001
`define ADCSR_ADDR_CTRL2 16'h0002
`define ADCSR_ADDR_OFFSET 16'h0003
`define ADCSR_ADDR_GAIN 16'h0004
`define ADCSR_ADDR_OVR_THR 16'h0005
// ==========================================================================
// Reset values of the writable registers.
`define ADCSR_RST_CTRL1 16'h001a
`define ADCSR_RST_CTRL2 16'h009b
`define ADCSR_RST_OFFSET 16'h0000
`define ADCSR_RST_GAIN 16'ha000
`define ADCSR_RST_OVR_THR 16'hcccc
// ==========================================================================
// Field positions in the first control register.
`define ADCSR_C1_DL_FILT 15
`define ADCSR_C1_RD_OVR 14
`define ADCSR_C1_RD_GAIN 13
`define ADCSR_C1_RD_OFF 12
`define ADCSR_C1_RD_STAT 11
`define ADCSR_C1_SYNC 9
`define ADCSR_C1_FLEN_LSB 5
`define ADCSR_C1_BYP3 4
`define ADCSR_C1_BYP1 3
// Field positions in the second control register.
`define ADCSR_C2_CDIV 5
`define ADCSR_C2_PD 3
`define ADCSR_C2_LOW_POWER_FLAG 2
`define ADCSR_C2_AMP_PD 0
// ==========================================================================
// Fixed part code, arbitrary neutral value.
`define ADCSR_PART_CODE 2'h1
// Consecutive full-scale modulator samples tolerated before overrange.
`define ADCSR_MOD_OVER_LIMIT 3'h4
`endif

// file: pkg/adcsr_pkg.sv
// Types shared by the ADC status and correction bank.
package adcsr_pkg;
   // ========================================================================
   // Source of the word returned by the next read.
   typedef enum logic [2:0] {
      ADCSR_RD_RESULT,
      ADCSR_RD_OVR,
      ADCSR_RD_GAIN,
      ADCSR_RD_OFF,
      ADCSR_RD_STAT
   } adcsr_rdsel_t;
   // Phase of the write protocol.
   typedef enum logic [1:0] {
      ADCSR_WR_ADDR,
      ADCSR_WR_DATA,
      ADCSR_WR_COEF
   } adcsr_wphase_t;
endpackage : adcsr_pkg

// file: verif/adcsr_host.sv
// Host model that writes and reads the bank over the parallel strobe pins.
`timescale 1ns/100ps
module adcsr_host (
   input wire logic core_clk,
   output logic bus_cs_n,
   output logic bus_wr_n,
   output logic bus_rd_n,
   output logic [15:0] host_data
);
   // Strobe length in cycles; the bench raises it to play a slow host.
   int hold = 4;
   initial begin
      bus_cs_n = 1'b1;
      bus_wr_n = 1'b1;
      bus_rd_n = 1'b1;
      host_data = 16'h0000;
   end
   // One write strobe; lines then show the inverse.
   task automatic strobe(input logic [15:0] w);
      bus_cs_n = 1'b0;
      host_data = w;
      bus_wr_n = 1'b0;
      repeat (hold) @(negedge core_clk);
      bus_wr_n = 1'b1;
      repeat (2) @(negedge core_clk);
      host_data = ~w;
      repeat (hold) @(negedge core_clk);
   endtask : strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      strobe(a);
      strobe(d);
   endtask : wr
   task automatic rd();
      bus_rd_n = 1'b0;
      repeat (6) @(negedge core_clk);
      bus_rd_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask : rd
endmodule : adcsr_host

// file: verif/adcsr_regs_chk.sv
// Checker of status fields, bus answer and result timing.
`timescale 1ns/100ps
`include "adcsr_params.svh"
module adcsr_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic bus_cs_n,
   input wire logic bus_rd_n,
   input wire logic bus_data_oe,
   input wire logic [2:0] die_strap,
   input wire logic mod_over_fs,
   input wire logic mod_valid,
   input wire logic raw_valid,
   input wire logic result_valid_out,
   input wire logic [15:0] device_status_word,
   input wire logic low_power_flag,
   input wire logic [2:0] decimation_select
);
   // Cycles since release.
   logic [2:0] age_r;
   // Full-scale modulator samples in a row.
   logic [2:0] run_r;
   logic [15:0] st;
   assign st = device_status_word;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
         age_r <= age_r + 3'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst || (mod_valid && !mod_over_fs)) begin
         run_r <= 3'h0;
      end else if (mod_valid && run_r != 3'h7) begin
         run_r <= run_r + 3'h1;
      end
   end
   // ======================================================================
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_part; age_r == 3'h7 |-> st[15:14] == `ADCSR_PART_CODE; endproperty
   a_part: assert property (p_part) else $error("part code wrong");
   property p_die; age_r == 3'h7 && $past(die_strap, 4) == die_strap |-> st[13:11] == die_strap;
   endproperty
   a_die: assert property (p_die) else $error("die index wrong");
   property p_valid; result_valid_out |-> ##[1:2] st[10]; endproperty
   a_valid: assert property (p_valid) else $error("valid flag missing");
   property p_low_power_flag; (age_r == 3'h7 && $stable(low_power_flag))[*3] |-> st[9] == low_power_flag;
   endproperty
   a_low_power_flag: assert property (p_low_power_flag) else $error("low power bit wrong");
   property p_ovr; mod_valid && mod_over_fs && run_r >= 3'h4 |-> ##[1:3] st[8]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrange not set");
   property p_dec; (age_r == 3'h7 && $stable(decimation_select))[*3] |->
      st[2:0] == decimation_select; endproperty
   a_dec: assert property (p_dec) else $error("decimation echo wrong");
   property p_lat; raw_valid |-> ##2 result_valid_out; endproperty
   a_lat: assert property (p_lat) else $error("result late");
   property p_oe; $fell(bus_rd_n) && !bus_cs_n |-> ##[3:6] bus_data_oe; endproperty
   a_oe: assert property (p_oe) else $error("read not answered");
   c_res: cover property (raw_valid);
   c_rd: cover property (bus_data_oe);
   c_ovr: cover property (st[8]);
endmodule : adcsr_chk
bind adcsr_regs adcsr_chk chk_u (.core_clk, .sys_rst, .bus_cs_n, .bus_rd_n, .bus_data_oe,
   .die_strap, .mod_over_fs, .mod_valid, .raw_valid, .result_valid_out, .device_status_word,
   .low_power_flag, .decimation_select);

// file: verif/adc_status_and_correction_regs_tb.sv
// Self-checking bench of the ADC status and correction bank.
`timescale 1ns/100ps
`include "adcsr_params.svh"
module adc_status_and_correction_regs_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic bus_cs_n, bus_wr_n, bus_rd_n, bus_data_oe, low_power_flag, oe_q = 1'b0;
   logic [15:0] host_data, bus_data_in, bus_data_out, device_status_word;
   logic [2:0] die_strap = 3'h0, decimation_select;
   logic signed [15:0] stage1_data = 16'h0000;
   logic signed [23:0] raw_result = 24'h000000, result_out;
   logic stage1_valid = 1'b0, mod_over_fs = 1'b0, mod_valid = 1'b0, raw_valid = 1'b0;
   logic result_valid_out, v = 1'b0, lp = 1'b0, o = 1'b0;
   logic [15:0] gain = `ADCSR_RST_GAIN, offs = 16'h0000, thr;
   logic [8:0] c1 = 9'h01a;
   logic [15:0] rq[$];
   logic [23:0] dq[$];
   int num_errors = 0;
   int checks = 0;
   always #5 core_clk = ~core_clk;
   // The bus line shows the device word while it drives, else the host's.
   assign bus_data_in = bus_data_oe ? bus_data_out : host_data;
   adcsr_host host_u (.core_clk, .bus_cs_n, .bus_wr_n, .bus_rd_n, .host_data);
   adcsr_regs dut_u (.core_clk, .sys_rst, .bus_cs_n, .bus_wr_n, .bus_rd_n, .bus_data_in,
      .bus_data_out, .bus_data_oe, .die_strap, .stage1_data, .stage1_valid, .mod_over_fs,
      .mod_valid, .raw_result, .raw_valid, .filt_coef_pass(v), .result_out,
      .result_valid_out, .device_status_word, .low_power_flag, .third_stage_pass_flag(),
      .first_stage_pass_flag(), .decimation_select, .filt_len(), .sync_pulse(),
      .power_down(), .amp_power_down(), .clk_div_bypass());
   // ======================================================================
   // Comparison and scoreboard
   task automatic chk16(input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk16
   task automatic chk24(input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk24
   // Oldest note matches each result and each read answer start.
   always @(negedge core_clk) begin
      if (result_valid_out === 1'b1) chk24(dq.pop_front(), result_out);
      if (bus_data_oe === 1'b1 && !oe_q) chk16(rq.pop_front(), bus_data_out);
      oe_q = bus_data_oe;
   end
   // Gain first, then offset worth two result steps, then clamp.
   function automatic logic [23:0] calc(input logic signed [23:0] r);
      logic signed [47:0] p;
      p = (r * $signed({1'b0, gain})) >>> 15;
      p = p + $signed(offs) * 48'sh2;
      if (p > 48'sh7fffff) return 24'h7fffff;
      if (p < -48'sh800000) return 24'h800000;
      return p[23:0];
   endfunction : calc
   function automatic logic [15:0] est();
      return {`ADCSR_PART_CODE, die_strap, v, lp, o, {3{v}}, c1[4:0]};
   endfunction : est
   task automatic sel(input logic [15:0] s, input logic [15:0] e);
      host_u.wr(`ADCSR_ADDR_CTRL1, s | {7'h00, c1});
      rq.push_back(e);
      host_u.rd();
   endtask : sel
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
      @(negedge core_clk);
   endtask : pulse
   task automatic results();
      num_errors += rq.size() + dq.size();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // ======================================================================
   // Main sequence
   initial begin
      void'($urandom(80050));
      die_strap = 3'($urandom);
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
      sel(16'h4000, `ADCSR_RST_OVR_THR);
      sel(16'h2000, `ADCSR_RST_GAIN);
      sel(16'h1000, `ADCSR_RST_OFFSET);
      sel(16'h0800, est());
      offs = 16'($urandom);
      gain = 16'($urandom);
      thr = 16'h0100 + 16'($urandom % 32'hfe00);
      host_u.wr(`ADCSR_ADDR_OFFSET, offs);
      host_u.wr(`ADCSR_ADDR_GAIN, gain);
      host_u.wr(`ADCSR_ADDR_OVR_THR, thr);
      host_u.wr(16'h0007, 16'hffff);
      sel(16'h4000, thr);
      sel(16'h2000, gain);
      sel(16'h1000, offs);
      host_u.wr(`ADCSR_ADDR_CTRL2, `ADCSR_RST_CTRL2 | 16'h0004);
      lp = 1'b1;
      c1 = {4'h0, 2'($urandom), 3'($urandom % 6)};
      host_u.wr(`ADCSR_ADDR_CTRL1, {7'h00, c1});
      sel(16'h0800, est());
      for (int i = 0; i < 8; i++) begin
         raw_result = (i < 2) ? {i[0], {23{~i[0]}}} : 24'($urandom);
         raw_valid = 1'b1;
         dq.push_back(calc(raw_result));
         @(negedge core_clk);
      end
      raw_valid = 1'b0;
      v = 1'b1;
      host_u.wr(`ADCSR_ADDR_CTRL1, 16'h8000 | c1);
      repeat (4) host_u.wr(16'h0000, 16'h0000);
      host_u.strobe(16'h0000);
      repeat (4) @(negedge core_clk);
      host_u.hold = 6;
      sel(16'h0800, est());
      stage1_data = 16'((thr >> 1) + 16'h0001);
      pulse(stage1_valid);
      o = 1'b1;
      sel(16'h0800, est());
      stage1_data = -16'(thr >> 1);
      pulse(stage1_valid);
      o = 1'b0;
      sel(16'h0800, est());
      mod_over_fs = 1'b1;
      repeat (4) pulse(mod_valid);
      sel(16'h0800, est());
      pulse(mod_valid);
      o = 1'b1;
      sel(16'h0800, est());
      results();
   end
   // Watchdog, about seven times the run.
   initial begin
      #50000;
      num_errors++;
      results();
   end
endmodule : adc_status_and_correction_regs_tb
